// ==== design/uv_oc_cc_pkg.sv ====
// Constants, decode tables and state encodings for the threshold register bank
package uv_oc_cc_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_FAULT_RESPONSE = 8'hD2;
  localparam logic [7:0] CMD_UV_LIMIT       = 8'hD4;
  localparam logic [7:0] CMD_CONSTANT_CURRENT_REFERENCE       = 8'hD5;
  localparam logic [7:0] CMD_OC_LIMIT       = 8'hD6;
  localparam logic [7:0] CMD_FAULT_MASK     = 8'hD8;

  // ==========================================================================
  // Fields and reset values
  localparam int          CODE_W        = 3;
  localparam int          RESP_OC_BIT   = 4;
  localparam int          RESP_UV_BIT   = 6;
  localparam int          MASK_UV_BIT   = 0;
  localparam int          MASK_OC_BIT   = 1;
  localparam logic [2:0]  UV_RST        = 3'h1;
  localparam logic [2:0]  CC_RST        = 3'h7;
  localparam logic [2:0]  OC_RST        = 3'h7;
  localparam logic [1:0]  MASK_RST      = 2'h1;
  localparam logic [9:0]  RESP_HICCUP   = 10'h3FF;
  localparam logic [9:0]  RESP_LATCH    = 10'h000;
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;

  // ==========================================================================
  // Protection response states
  typedef enum logic [1:0] {
    PROT_RUN     = 2'b00,
    PROT_HICCUP  = 2'b01,
    PROT_LATCHED = 2'b10
  } protect_t;

  // ==========================================================================
  // Decode tables: per-mille of output reference, millivolts
  function automatic logic [9:0] uvPermilleOf(input logic [2:0] code);
    case (code)
      3'h0:    uvPermilleOf = 10'h2EE;
      3'h1:    uvPermilleOf = 10'h320;
      3'h2:    uvPermilleOf = 10'h339;
      3'h3:    uvPermilleOf = 10'h352;
      3'h4:    uvPermilleOf = 10'h36B;
      3'h5:    uvPermilleOf = 10'h384;
      3'h6:    uvPermilleOf = 10'h39D;
      default: uvPermilleOf = 10'h3B6;
    endcase
  endfunction

  function automatic logic [10:0] ccRefMvOf(input logic [2:0] code);
    case (code)
      3'h0:    ccRefMvOf = 11'h4E2;
      3'h1:    ccRefMvOf = 11'h514;
      3'h2:    ccRefMvOf = 11'h546;
      3'h3:    ccRefMvOf = 11'h578;
      3'h4:    ccRefMvOf = 11'h5AA;
      3'h5:    ccRefMvOf = 11'h5DC;
      3'h6:    ccRefMvOf = 11'h60E;
      default: ccRefMvOf = 11'h640;
    endcase
  endfunction

  function automatic logic [10:0] ocMvOf(input logic [2:0] code);
    case (code)
      3'h0:    ocMvOf = 11'h3E8;
      3'h1:    ocMvOf = 11'h47E;
      3'h2:    ocMvOf = 11'h4E2;
      3'h3:    ocMvOf = 11'h578;
      3'h4:    ocMvOf = 11'h60E;
      3'h5:    ocMvOf = 11'h6A4;
      3'h6:    ocMvOf = 11'h73A;
      default: ocMvOf = 11'h7D0;
    endcase
  endfunction

endpackage

// ==== design/pin_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= '0;
      pinSync <= '0;
    end else begin
      meta_q  <= pinIn;
      pinSync <= meta_q;
    end
  end

endmodule // pin_sync

// ==== design/fault_channel.sv ====
// Gated fault detector with sticky status flag and one-cycle event pulse
`timescale 1ns/10ps
module fault_channel (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic compare,
  input  wire logic gate,
  input  wire logic clear,
  output logic      status_q,
  output logic      event_q
);

  logic qualified;
  logic prevQual_q;

  assign qualified = compare & gate;

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_q   <= 1'b0;
      event_q    <= 1'b0;
      prevQual_q <= 1'b0;
    end else begin
      status_q   <= qualified | (status_q & ~clear);
      event_q    <= qualified & ~prevQual_q;
      prevQual_q <= qualified;
    end
  end

endmodule // fault_channel

// ==== design/uv_ocavg_cc_threshold_regs.sv ====
// Undervoltage, constant-current and average overcurrent threshold registers
`timescale 1ns/10ps
module uv_ocavg_cc_threshold_regs
  import uv_oc_cc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              cmdValid,
  input  wire logic              cmdWrite,
  input  wire logic [7:0]        cmdCode,
  input  wire logic [DATA_W-1:0] cmdWrData,
  input  wire logic              writeProtect,
  output logic      [DATA_W-1:0] rdData,
  output logic                   rdValid,
  output logic                   cmdError,
  input  wire logic              feedbackPin,
  input  wire logic              currentMonitorPin,
  input  wire logic              converterEnable,
  input  wire logic              restartPolicyStrap,
  input  wire logic              softStartActive,
  input  wire logic              softStartDone,
  input  wire logic              faultClear,
  input  wire logic              restartDone,
  output logic      [9:0]        uvPermille,
  output logic      [10:0]       currentLoopReference,
  output logic      [10:0]       ocThresholdMv,
  output logic                   outputUndervoltFault,
  output logic                   averageOvercurrentFault,
  output logic                   alertOutput,
  output logic                   alertOe,
  output logic                   shutdownReq,
  output logic                   hiccupActive,
  output logic                   latchedOff
);

  if (DATA_W != 16) begin : g_width_check
    $error("DATA_W must be 16 to carry the two-byte response word");
  end

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] pinsSync;
  logic       uvCompare;
  logic       ocCompare;
  logic       enableSync;
  logic       strapSync;

  pin_sync #(.WIDTH(4)) u_pin_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .pinIn   ({restartPolicyStrap, converterEnable, currentMonitorPin, feedbackPin}),
    .pinSync (pinsSync)
  );

  assign uvCompare  = pinsSync[0];
  assign ocCompare  = pinsSync[1];
  assign enableSync = pinsSync[2];
  assign strapSync  = pinsSync[3];

  // ==========================================================================
  // Command decode
  logic [2:0] uvCode_q;
  logic [2:0] ccCode_q;
  logic [2:0] ocCode_q;
  logic [1:0] mask_q;
  logic [9:0] resp_q;
  logic [1:0] strapCnt_q;
  logic       strapTaken_q;

  wire hitUv   = (cmdCode == CMD_UV_LIMIT);
  wire hitCc   = (cmdCode == CMD_CONSTANT_CURRENT_REFERENCE);
  wire hitOc   = (cmdCode == CMD_OC_LIMIT);
  wire hitResp = (cmdCode == CMD_FAULT_RESPONSE);
  wire hitMask = (cmdCode == CMD_FAULT_MASK);
  wire mapped  = hitUv | hitCc | hitOc | hitResp | hitMask;
  wire wrOk    = cmdValid & cmdWrite & ~writeProtect & mapped;
  wire rdReq   = cmdValid & ~cmdWrite;
  wire badCmd  = cmdValid & (~mapped | (cmdWrite & writeProtect));
  wire strapLoad = ~strapTaken_q & (strapCnt_q == STRAP_WAIT);

  logic [DATA_W-1:0] rdSel;
  always_comb begin
    rdSel = '0;
    if (hitUv) begin
      rdSel[2:0] = uvCode_q;
    end else if (hitCc) begin
      rdSel[2:0] = ccCode_q;
    end else if (hitOc) begin
      rdSel[2:0] = ocCode_q;
    end else if (hitResp) begin
      rdSel[9:0] = resp_q;
    end else if (hitMask) begin
      rdSel[1:0] = mask_q;
    end
  end

  // ==========================================================================
  // Limit registers: only bits 2:0 stored; fault mask stores bits 1:0
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      uvCode_q <= UV_RST;
      ccCode_q <= CC_RST;
      ocCode_q <= OC_RST;
      mask_q   <= MASK_RST;
    end else if (wrOk) begin
      if (hitUv) uvCode_q <= cmdWrData[2:0];
      if (hitCc) ccCode_q <= cmdWrData[2:0];
      if (hitOc) ocCode_q <= cmdWrData[2:0];
      if (hitMask) mask_q <= cmdWrData[1:0];
    end
  end

  // Strap is caught once the synchroniser has filled after reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resp_q       <= RESP_LATCH;
      strapCnt_q   <= 2'h0;
      strapTaken_q <= 1'b0;
    end else begin
      if (!strapTaken_q) strapCnt_q <= strapCnt_q + 2'h1;
      if (strapLoad) begin
        strapTaken_q <= 1'b1;
        resp_q       <= strapSync ? RESP_HICCUP : RESP_LATCH;
      end else if (wrOk && hitResp) begin
        resp_q <= cmdWrData[9:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdData   <= '0;
      rdValid  <= 1'b0;
      cmdError <= 1'b0;
    end else begin
      rdValid  <= rdReq & mapped;
      cmdError <= badCmd;
      if (rdReq) rdData <= rdSel;
    end
  end

  // ==========================================================================
  // Decoded thresholds, one cycle behind the stored code
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      uvPermille           <= uvPermilleOf(UV_RST);
      currentLoopReference <= ccRefMvOf(CC_RST);
      ocThresholdMv        <= ocMvOf(OC_RST);
    end else begin
      uvPermille           <= uvPermilleOf(uvCode_q);
      currentLoopReference <= ccRefMvOf(ccCode_q);
      ocThresholdMv        <= ocMvOf(ocCode_q);
    end
  end

  // ==========================================================================
  // Fault detection
  logic uvEvent;
  logic ocEvent;
  wire  uvGate = enableSync & softStartDone;
  wire  ocGate = enableSync & (softStartActive | softStartDone);

  fault_channel u_uv_channel (
    .mclk     (mclk),
    .resetn   (resetn),
    .compare  (uvCompare),
    .gate     (uvGate),
    .clear    (faultClear),
    .status_q (outputUndervoltFault),
    .event_q  (uvEvent)
  );

  fault_channel u_oc_channel (
    .mclk     (mclk),
    .resetn   (resetn),
    .compare  (ocCompare),
    .gate     (ocGate),
    .clear    (faultClear),
    .status_q (averageOvercurrentFault),
    .event_q  (ocEvent)
  );

  // Open-drain alert: pin level is always low, enable carries the state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alertOutput <= 1'b0;
      alertOe     <= 1'b0;
    end else begin
      alertOutput <= 1'b0;
      alertOe     <= outputUndervoltFault | averageOvercurrentFault;
    end
  end

  // ==========================================================================
  // Protection response
  protect_t state_q;
  protect_t state_d;
  wire uvAct   = uvEvent & ~mask_q[MASK_UV_BIT];
  wire ocAct   = ocEvent & ~mask_q[MASK_OC_BIT];
  // Any acting fault set to latch-off wins over hiccup
  wire anyLatch = (uvAct & ~resp_q[RESP_UV_BIT])
                | (ocAct & ~resp_q[RESP_OC_BIT]);

  always_comb begin
    state_d = state_q;
    case (state_q)
      PROT_RUN: begin
        if (uvAct | ocAct) state_d = anyLatch ? PROT_LATCHED : PROT_HICCUP;
      end
      PROT_HICCUP: begin
        if (anyLatch) state_d = PROT_LATCHED;
        else if (restartDone) state_d = PROT_RUN;
      end
      PROT_LATCHED: begin
        // Only a disable releases a latched shutdown
        if (!enableSync) state_d = PROT_RUN;
      end
      default: state_d = PROT_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= PROT_RUN;
      shutdownReq  <= 1'b0;
      hiccupActive <= 1'b0;
      latchedOff   <= 1'b0;
    end else begin
      state_q      <= state_d;
      shutdownReq  <= (state_d != PROT_RUN);
      hiccupActive <= (state_d == PROT_HICCUP);
      latchedOff   <= (state_d == PROT_LATCHED);
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence wrUvSeq;
    cmdValid && cmdWrite && !writeProtect && cmdCode == CMD_UV_LIMIT;
  endsequence

  sequence wrCcSeq;
    cmdValid && cmdWrite && !writeProtect && cmdCode == CMD_CONSTANT_CURRENT_REFERENCE;
  endsequence

  sequence wrOcSeq;
    cmdValid && cmdWrite && !writeProtect && cmdCode == CMD_OC_LIMIT;
  endsequence

  a_uv_threshold_decode: assert property (
    wrUvSeq ##1 !(wrOk && hitUv)
    |=> uvPermille == uvPermilleOf($past(cmdWrData[2:0], 2)))
    else $error("UV threshold not decoded from written code");

  a_cc_loop_reference: assert property (
    wrCcSeq ##1 !(wrOk && hitCc)
    |=> currentLoopReference == ccRefMvOf($past(cmdWrData[2:0], 2)))
    else $error("CC reference not decoded from written code");

  a_oc_threshold_decode: assert property (
    wrOcSeq ##1 !(wrOk && hitOc)
    |=> ocThresholdMv == ocMvOf($past(cmdWrData[2:0], 2)))
    else $error("OC threshold not decoded from written code");

  a_protect_blocks_write: assert property (
    cmdValid && cmdWrite && writeProtect
    |=> $stable(uvCode_q) && $stable(ccCode_q) && $stable(ocCode_q) && cmdError)
    else $error("Protected write changed a limit register");

  a_unused_bits_zero: assert property (
    cmdValid && !cmdWrite && (hitUv || hitCc || hitOc) |=> rdValid && rdData[15:3] == '0)
    else $error("Unused limit bits read non-zero");

  a_uv_gated_start: assert property (
    $rose(outputUndervoltFault) |-> $past(uvGate))
    else $error("UV fault raised while gated off");

  a_oc_gated_start: assert property (
    $rose(averageOvercurrentFault) |-> $past(ocGate))
    else $error("OC fault raised outside soft-start or run");

  a_alert_follows_fault: assert property (
    outputUndervoltFault || averageOvercurrentFault |=> alertOe && !alertOutput)
    else $error("Alert not driven low during fault");

  a_uv_mask_no_shutdown: assert property (
    state_q == PROT_RUN && uvEvent && mask_q[MASK_UV_BIT] && !ocAct |=> !shutdownReq)
    else $error("Masked UV fault caused shutdown");

  a_oc_hiccup_select: assert property (
    state_q == PROT_RUN && ocAct && resp_q[RESP_OC_BIT] && !uvAct
    |=> hiccupActive && shutdownReq)
    else $error("OC hiccup response not taken");

  a_uv_latch_select: assert property (
    state_q == PROT_RUN && uvAct && !resp_q[RESP_UV_BIT] |=> latchedOff ##1 latchedOff || !enableSync)
    else $error("UV latch-off response not taken");

  a_oc_mask_no_shutdown: assert property (
    state_q == PROT_RUN && ocEvent && mask_q[MASK_OC_BIT] && !uvAct |=> !shutdownReq)
    else $error("Masked OC fault caused shutdown");

  a_uv_status_set: assert property (
    uvCompare && uvGate |=> outputUndervoltFault)
    else $error("Qualified UV compare did not set status");

  a_oc_status_set: assert property (
    ocCompare && ocGate |=> averageOvercurrentFault)
    else $error("Qualified OC compare did not set status");

  a_strap_sets_response: assert property (
    strapLoad |=> resp_q == ($past(strapSync) ? RESP_HICCUP : RESP_LATCH))
    else $error("Response word not loaded from strap");

  a_read_returns_code: assert property (
    cmdValid && !cmdWrite && hitCc |=> rdData[2:0] == $past(ccCode_q))
    else $error("CC read data differs from stored code");

  a_latch_holds_enabled: assert property (
    state_q == PROT_LATCHED && enableSync |=> latchedOff)
    else $error("Latched shutdown released while enabled");

endmodule // uv_ocavg_cc_threshold_regs

// ==== test/pmbus_host_model.sv ====
// Command-level host model driving the register command port
`timescale 1ns/10ps
module pmbus_host_model (
  input  wire logic        mclk,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdCode,
  output logic [15:0]      cmdWrData,
  input  wire logic [15:0] rdData,
  input  wire logic        rdValid,
  input  wire logic        cmdError
);
  logic [15:0] lastRd;
  logic        lastRdValid;
  logic        lastError;

  initial begin
    cmdValid  = 1'b0;
    cmdWrite  = 1'b0;
    cmdCode   = 8'h00;
    cmdWrData = 16'h0000;
  end

  // ====================
  // One command: idle gap, one-cycle strobe, answer one cycle later
  task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    cmdValid  <= 1'b1;
    cmdWrite  <= wr;
    cmdCode   <= code;
    cmdWrData <= data;
    @(posedge mclk);
    // Released lines move so a stale value never looks valid
    cmdValid  <= 1'b0;
    cmdWrite  <= ~wr;
    cmdCode   <= ~code;
    cmdWrData <= ~data;
    @(negedge mclk);
    lastRd      = rdData;
    lastRdValid = rdValid;
    lastError   = cmdError;
  endtask
endmodule // pmbus_host_model

// ==== test/uv_ocavg_cc_threshold_regs_tb_top.sv ====
// Self-checking bench for the threshold register bank
`timescale 1ns/10ps
module uv_ocavg_cc_threshold_regs_tb_top;
  import uv_oc_cc_pkg::*;
  logic        mclk, resetn, cmdValid, cmdWrite, writeProtect, rdValid, cmdError;
  logic        feedbackPin, currentMonitorPin, converterEnable, restartPolicyStrap;
  logic        softStartActive, softStartDone, faultClear, restartDone;
  logic        outputUndervoltFault, averageOvercurrentFault, alertOutput, alertOe;
  logic        shutdownReq, hiccupActive, latchedOff;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWrData, rdData;
  logic [9:0]  uvPermille;
  logic [10:0] currentLoopReference, ocThresholdMv;
  int          mismatches, nCompared;
  int          uvTab[8] = '{750, 800, 825, 850, 875, 900, 925, 950};
  int          ocTab[8] = '{1000, 1150, 1250, 1400, 1550, 1700, 1850, 2000};
  int          regCode[3] = '{1, 7, 7};
  logic [7:0]  limCode[3] = '{CMD_UV_LIMIT, CMD_CONSTANT_CURRENT_REFERENCE, CMD_OC_LIMIT};

  uv_ocavg_cc_threshold_regs DUT (
    .mclk(mclk), .resetn(resetn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdWrData(cmdWrData), .writeProtect(writeProtect),
    .rdData(rdData), .rdValid(rdValid), .cmdError(cmdError),
    .feedbackPin(feedbackPin), .currentMonitorPin(currentMonitorPin),
    .converterEnable(converterEnable), .restartPolicyStrap(restartPolicyStrap),
    .softStartActive(softStartActive), .softStartDone(softStartDone),
    .faultClear(faultClear), .restartDone(restartDone), .uvPermille(uvPermille),
    .currentLoopReference(currentLoopReference), .ocThresholdMv(ocThresholdMv),
    .outputUndervoltFault(outputUndervoltFault),
    .averageOvercurrentFault(averageOvercurrentFault), .alertOutput(alertOutput),
    .alertOe(alertOe), .shutdownReq(shutdownReq), .hiccupActive(hiccupActive),
    .latchedOff(latchedOff)
  );

  pmbus_host_model host (
    .mclk(mclk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid), .cmdError(cmdError)
  );

  always #50 mclk = ~mclk;

  // ====================
  // Shared checks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic chkDecoded();
    chk("uvPermille", 16'(uvTab[regCode[0]]), 16'(uvPermille));
    chk("ccRef", 16'(1250 + 50 * regCode[1]), 16'(currentLoopReference));
    chk("ocThresholdMv", 16'(ocTab[regCode[2]]), 16'(ocThresholdMv));
  endtask

  task automatic rd(input logic [7:0] code, input int exp);
    host.issue(1'b0, code, 16'h0000, $urandom_range(2));
    chk("rdValid", 16'h0001, 16'(host.lastRdValid));
    chk("rdData", 16'(exp), host.lastRd);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic expErr);
    host.issue(1'b1, code, data, $urandom_range(2));
    chk("cmdError", 16'(expErr), 16'(host.lastError));
  endtask

  task automatic clearFaults();
    @(posedge mclk);
    faultClear <= 1'b1;
    @(posedge mclk);
    faultClear <= 1'b0;
    cyc(2);
  endtask

  task automatic summarize();
    if (mismatches == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    mismatches++;
    summarize();
  end

  // ====================
  // Main sequence
  initial begin
    logic [4:0] up;
    mclk = 1'b0;
    resetn = 1'b0;
    writeProtect = 1'b0;
    feedbackPin = 1'b0;
    currentMonitorPin = 1'b0;
    converterEnable = 1'b0;
    restartPolicyStrap = 1'b1;
    softStartActive = 1'b0;
    softStartDone = 1'b0;
    faultClear = 1'b0;
    restartDone = 1'b0;
    void'($urandom(32'h0aba_37b9));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    cyc(0);
    chkDecoded();
    chk("alertAtReset", 16'h0000, 16'(alertOe));
    cyc(4);
    rd(CMD_UV_LIMIT, 1);
    rd(CMD_CONSTANT_CURRENT_REFERENCE, 7);
    rd(CMD_OC_LIMIT, 7);
    rd(CMD_FAULT_RESPONSE, 16'h03ff);
    rd(CMD_FAULT_MASK, 1);
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 8; c++) begin
        up = 5'($urandom_range(31));
        wr(limCode[i], {8'h00, up, 3'(c)}, 1'b0);
        regCode[i] = c;
        cyc(2);
        chkDecoded();
        rd(limCode[i], c);
      end
    end
    @(posedge mclk);
    writeProtect <= 1'b1;
    wr(CMD_CONSTANT_CURRENT_REFERENCE, 16'h0002, 1'b1);
    rd(CMD_CONSTANT_CURRENT_REFERENCE, regCode[1]);
    @(posedge mclk);
    writeProtect <= 1'b0;
    host.issue(1'b0, 8'hd7, 16'h0000, 0);
    chk("unmappedRdValid", 16'h0000, 16'(host.lastRdValid));
    chk("unmappedError", 16'h0001, 16'(host.lastError));
    // Undervoltage path: held off until soft-start is done
    @(posedge mclk);
    converterEnable <= 1'b1;
    feedbackPin <= 1'b1;
    cyc(6);
    chk("uvBeforeSoftStart", 16'h0000, 16'(outputUndervoltFault));
    @(posedge mclk);
    softStartDone <= 1'b1;
    cyc(3);
    chk("uvFault", 16'h0001, 16'(outputUndervoltFault));
    cyc(1);
    chk("uvAlert", 16'h0001, 16'(alertOe));
    chk("alertLevel", 16'h0000, 16'(alertOutput));
    chk("uvMaskedShutdown", 16'h0000, 16'(shutdownReq));
    @(posedge mclk);
    feedbackPin <= 1'b0;
    converterEnable <= 1'b0;
    cyc(3);
    clearFaults();
    chk("alertReleased", 16'h0000, 16'(alertOe));
    @(posedge mclk);
    feedbackPin <= 1'b1;
    cyc(6);
    chk("uvWhileDisabled", 16'h0000, 16'(outputUndervoltFault));
    // Overcurrent path: live during the soft-start ramp
    @(posedge mclk);
    feedbackPin <= 1'b0;
    softStartDone <= 1'b0;
    softStartActive <= 1'b1;
    converterEnable <= 1'b1;
    currentMonitorPin <= 1'b1;
    cyc(3);
    chk("ocFault", 16'h0001, 16'(averageOvercurrentFault));
    cyc(1);
    chk("ocShutdown", 16'h0001, 16'(shutdownReq));
    chk("ocHiccup", 16'h0001, 16'(hiccupActive));
    @(posedge mclk);
    currentMonitorPin <= 1'b0;
    restartDone <= 1'b1;
    @(posedge mclk);
    restartDone <= 1'b0;
    cyc(1);
    chk("hiccupExit", 16'h0000, 16'(hiccupActive));
    clearFaults();
    wr(CMD_FAULT_RESPONSE, 16'h03ef, 1'b0);
    @(posedge mclk);
    currentMonitorPin <= 1'b1;
    cyc(4);
    chk("ocLatch", 16'h0001, 16'(latchedOff));
    @(posedge mclk);
    currentMonitorPin <= 1'b0;
    converterEnable <= 1'b0;
    cyc(4);
    chk("latchExit", 16'h0000, 16'(latchedOff));
    clearFaults();
    wr(CMD_FAULT_MASK, 16'h0000, 1'b0);
    wr(CMD_FAULT_RESPONSE, 16'h03af, 1'b0);
    rd(CMD_FAULT_RESPONSE, 16'h03af);
    @(posedge mclk);
    converterEnable <= 1'b1;
    softStartActive <= 1'b0;
    softStartDone <= 1'b1;
    feedbackPin <= 1'b1;
    cyc(4);
    chk("uvUnmaskedShutdown", 16'h0001, 16'(shutdownReq));
    chk("uvLatch", 16'h0001, 16'(latchedOff));
    // OC masked, UV unmasked with hiccup response
    @(posedge mclk);
    feedbackPin <= 1'b0;
    converterEnable <= 1'b0;
    cyc(4);
    clearFaults();
    wr(CMD_FAULT_MASK, 16'h0002, 1'b0);
    wr(CMD_FAULT_RESPONSE, 16'h03ff, 1'b0);
    @(posedge mclk);
    converterEnable <= 1'b1;
    currentMonitorPin <= 1'b1;
    cyc(4);
    chk("ocMaskedFault", 16'h0001, 16'(averageOvercurrentFault));
    chk("ocMaskedShutdown", 16'h0000, 16'(shutdownReq));
    clearFaults();
    chk("setBeatsClear", 16'h0001, 16'(averageOvercurrentFault));
    @(posedge mclk);
    feedbackPin <= 1'b1;
    cyc(4);
    chk("uvHiccup", 16'h0001, 16'(hiccupActive));
    summarize();
  end
endmodule // uv_ocavg_cc_threshold_regs_tb_top
